// [qsm_fifo.sv]
// Dual-clock FIFO with gray pointers and registered read data
module qsm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             wclk_i,
  input  wire logic             wrst_n_i,
  input  wire logic             w_valid_i,
  output logic                  w_ready_o,
  input  wire logic [WIDTH-1:0] w_data_i,
  input  wire logic             rclk_i,
  input  wire logic             rrst_i,
  output logic                  r_valid_o,
  input  wire logic             r_ready_i,
  output logic      [WIDTH-1:0] r_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rq1_reg;
  logic [AW:0]      rq2_reg;
  logic [AW:0]      wbin_next;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      rbin_next;
  logic [AW:0]      wq;
  logic             push;
  logic             load;
  logic             empty;

  // ==========================================================================
  // Write side, on the link clock
  assign wbin_next = wbin_reg + 1'b1;
  // Full is judged on a stale read pointer, so it errs towards full
  assign w_ready_o = wgray_reg != {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
  assign push      = w_valid_i & w_ready_o;

  always_ff @(posedge wclk_i or negedge wrst_n_i) begin
    if (!wrst_n_i) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rq1_reg   <= '0;
      rq2_reg   <= '0;
    end else begin
      rq1_reg <= rgray_reg;
      rq2_reg <= rq1_reg;
      if (push) begin
        wbin_reg  <= wbin_next;
        wgray_reg <= (wbin_next >> 1) ^ wbin_next;
      end
    end
  end

  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= w_data_i;
    end
  end

  // ==========================================================================
  // Read side, on the system clock
  qsm_sync #(
    .WIDTH (AW + 1)
  ) u_wptr_sync (
    .clock_i (rclk_i),
    .reset_i (rrst_i),
    .d_i     (wgray_reg),
    .q_o     (wq)
  );

  assign rbin_next = rbin_reg + 1'b1;
  assign empty     = rgray_reg == wq;
  assign load      = !empty && (!r_valid_o || r_ready_i);

  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      r_valid_o <= 1'b0;
      r_data_o  <= '0;
    end else if (load) begin
      r_data_o  <= mem[rbin_reg[AW-1:0]];
      rbin_reg  <= rbin_next;
      rgray_reg <= (rbin_next >> 1) ^ rbin_next;
      r_valid_o <= 1'b1;
    end else if (r_ready_i) begin
      r_valid_o <= 1'b0;
    end
  end

endmodule : qsm_fifo

// [qsm_host_model.sv]
// Host controller model driving the die-two serial link
module qsm_host_model (
  output logic            select_n_o,
  output logic            sclk_o,
  output logic            si_o,
  output logic      [3:0] dq_o,
  output logic            dq_oe_o,
  input  wire logic       so_i,
  input  wire logic [3:0] dq_i
);
  timeunit 1ns;
  timeprecision 10ps;
  // ========
  // Frame tasks
  bit m3;
  initial begin
    select_n_o = 1;
    sclk_o = 0;
    si_o = 0;
    dq_o = 4'h0;
    dq_oe_o = 0;
  end
  // Clock parked at idle level before select falls, so mode is defined
  task automatic start(input bit mode3);
    m3 = mode3;
    sclk_o = mode3;
    #7.5 select_n_o = 0;
    #7.5;
  endtask : start
  task automatic stop();
    #3.75 sclk_o = m3;
    dq_oe_o = 0;
    #7.5 select_n_o = 1;
    #7.5;
  endtask : stop
  // Data set while clock low, sampled before the rising edge
  task automatic xb(input bit q, input logic [7:0] tx, input bit drv, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      sclk_o = 0;
      dq_oe_o = drv & q;
      if (q) dq_o = tx[7-4*i -: 4];
      else si_o = tx[7-i];
      #7.5 rx = q ? {rx[3:0], dq_i} : {rx[6:0], so_i};
      sclk_o = 1;
      #7.5;
    end
  endtask : xb
  // High nibble on rising edge, low nibble on falling edge
  task automatic ddr(input logic [7:0] tx);
    sclk_o = 0;
    dq_oe_o = 1;
    #3.75 dq_o = tx[7:4];
    #3.75 sclk_o = 1;
    #3.75 dq_o = tx[3:0];
    #3.75;
  endtask : ddr
  // Trailing rising edge, else the last double-rate byte is lost
  task automatic pulse();
    sclk_o = 0;
    #7.5 sclk_o = 1;
    #7.5;
  endtask : pulse
  // High nibble stands while clock high, low nibble after the fall
  task automatic ddr_rd(output logic [7:0] rx);
    dq_oe_o = 0;
    rx[7:4] = dq_i;
    sclk_o = 0;
    #7.5 rx[3:0] = dq_i;
    sclk_o = 1;
    #7.5;
  endtask : ddr_rd
  // Whole write-status frame with select left high
  task automatic noise();
    logic [7:0] r;
    xb(0, 8'h01, 0, r);
    xb(0, 8'h40, 0, r);
    sclk_o = 0;
  endtask : noise
endmodule : qsm_host_model

// [qsm_pkg.sv]
// Shared constants and types for the die-two serial memory port
package qsm_pkg;

  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_DATA   = 8'h02;
  localparam logic [7:0] CMD_READ_DATA    = 8'h03;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h05;

  // ==========================================================================
  // Status register layout and reset value
  localparam int         STAT_PROTECT_BIT = 7;
  localparam int         STAT_QUAD_BIT    = 6;
  localparam int         STAT_DDR_BIT     = 5;
  localparam logic [7:0] STATUS_RESET     = 8'h00;

  // ==========================================================================
  // Widths, counts and depths
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 8;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] QUAD_STEP  = 4'h4;
  localparam logic [3:0] WIRE_STEP  = 4'h1;

  // ==========================================================================
  // Frame states
  typedef enum logic [6:0] {
    ST_CMD   = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_WDATA = 7'b000_0100,
    ST_WSTAT = 7'b000_1000,
    ST_RSTAT = 7'b001_0000,
    ST_RDATA = 7'b010_0000,
    ST_ABORT = 7'b100_0000
  } qsm_state_t;

endpackage : qsm_pkg

// [qsm_port.sv]
// Die-two serial memory port: pin-level frame logic, status, error flag
module qsm_port (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       die_two_select_n_i,
  input  wire logic       die_two_serial_clock_i,
  input  wire logic       die_two_reset_n_i,
  input  wire logic       die_two_serial_in_i,
  output logic            die_two_serial_out_o,
  output logic            die_two_serial_out_oe_o,
  input  wire logic       die_two_status_guard_n_i,
  input  wire logic [3:0] data_line_i,
  output logic      [3:0] data_line_o,
  output logic      [3:0] data_line_oe_o,
  output logic            die_two_uncorrectable_irq_n_o,
  output logic            write_valid_o,
  input  wire logic       write_ready_i,
  output logic      [7:0] write_addr_o,
  output logic      [7:0] write_data_o,
  input  wire logic       read_load_i,
  input  wire logic [7:0] read_word_i,
  input  wire logic       read_uncorrectable_i,
  output logic            die_active_o,
  output logic            quad_mode_o,
  output logic            double_rate_o
);

  // ==========================================================================
  // State types
  typedef struct packed {
    qsm_pkg::qsm_state_t state;
    logic [3:0]          cnt;
    logic [7:0]          shift;
    logic [7:0]          addr;
    logic [7:0]          tx;
    logic                have_rise;
    logic [3:0]          hold_rise;
    logic [3:0]          out_rise;
  } qsm_frame_t;

  typedef struct packed {
    logic [3:0] out_fall;
    logic [3:0] fall_nib;
  } qsm_fall_t;

  typedef struct packed {
    logic [7:0] status;
    logic       irq_n;
    logic       tg1;
    logic       tg2;
    logic       tg3;
    logic [8:0] shadow;
  } qsm_persist_t;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic [8:0] hold;
    logic       tog;
  } qsm_core_t;

  localparam qsm_frame_t FRAME_RESET = '{state: qsm_pkg::ST_CMD, default: '0};
  localparam qsm_persist_t PERSIST_RESET = '{status: qsm_pkg::STATUS_RESET, irq_n: 1'b1, default: '0};

  qsm_frame_t   r_reg;
  qsm_frame_t   r_next;
  qsm_fall_t    f_reg;
  qsm_fall_t    f_next;
  qsm_persist_t p_reg;
  qsm_persist_t p_next;
  qsm_core_t    c_reg;
  qsm_core_t    c_next;
  logic         mode3_reg;

  logic         frame_clr;
  logic         quad;
  logic         ddr_on;
  logic         ddr_data;
  logic         read_state;
  logic [3:0]   wbits;
  logic [7:0]   byte_in;
  logic [7:0]   read_byte;
  logic [7:0]   tx_sel;
  logic [3:0]   dout;
  logic         done;
  logic         push;
  logic         fifo_ready;
  logic         st_we;
  logic         rd_start;
  logic         oe_read;
  logic [15:0]  fifo_out;

  // ==========================================================================
  // Mode decode
  // Async clear from pins: a select glitch only restarts the frame
  assign frame_clr  = die_two_select_n_i | ~die_two_reset_n_i;
  assign quad       = p_reg.status[qsm_pkg::STAT_QUAD_BIT];
  assign ddr_on     = p_reg.status[qsm_pkg::STAT_DDR_BIT] & quad & ~mode3_reg;
  assign ddr_data   = ddr_on & (r_reg.state != qsm_pkg::ST_CMD);
  assign wbits      = quad ? qsm_pkg::QUAD_STEP : qsm_pkg::WIRE_STEP;
  assign read_state = (r_reg.state == qsm_pkg::ST_RSTAT) || (r_reg.state == qsm_pkg::ST_RDATA);
  assign read_byte  = (r_reg.state == qsm_pkg::ST_RDATA) ? p_reg.shadow[7:0] : p_reg.status;

  // ==========================================================================
  // Clock level at select fall chooses mode 0 or 3
  always_ff @(negedge die_two_select_n_i or negedge die_two_reset_n_i) begin
    if (!die_two_reset_n_i) begin
      mode3_reg <= 1'b0;
    end else begin
      mode3_reg <= die_two_serial_clock_i;
    end
  end

  // ==========================================================================
  // Rising-edge frame logic
  always_comb begin
    r_next   = r_reg;
    byte_in  = 8'h00;
    done     = 1'b0;
    push     = 1'b0;
    st_we    = 1'b0;
    rd_start = 1'b0;
    if (ddr_data) begin
      // Byte pairs the previous rising nibble with the falling one
      byte_in          = {r_reg.hold_rise, f_reg.fall_nib};
      done             = r_reg.have_rise;
      r_next.hold_rise = data_line_i;
      r_next.have_rise = 1'b1;
    end else begin
      byte_in      = quad ? {r_reg.shift[3:0], data_line_i} : {r_reg.shift[6:0], die_two_serial_in_i};
      r_next.shift = byte_in;
      r_next.cnt   = r_reg.cnt + wbits;
      done         = r_next.cnt == qsm_pkg::BYTE_BITS;
      if (done) begin
        r_next.cnt = 4'h0;
      end
    end
    if (ddr_data && read_state) begin
      r_next.tx       = read_byte;
      r_next.out_rise = read_byte[7:4];
      rd_start        = r_reg.state == qsm_pkg::ST_RDATA;
    end else if (done) begin
      case (r_reg.state)
        qsm_pkg::ST_CMD: begin
          r_next.state = qsm_pkg::ST_ABORT;
          case (byte_in)
            qsm_pkg::CMD_WRITE_STATUS: begin
              if (!(p_reg.status[qsm_pkg::STAT_PROTECT_BIT] && !quad && !die_two_status_guard_n_i)) begin
                r_next.state = qsm_pkg::ST_WSTAT;
              end
            end
            qsm_pkg::CMD_WRITE_DATA: begin
              r_next.state = qsm_pkg::ST_ADDR;
            end
            qsm_pkg::CMD_READ_STATUS: begin
              r_next.state    = qsm_pkg::ST_RSTAT;
              r_next.tx       = p_reg.status;
              r_next.out_rise = p_reg.status[7:4];
            end
            qsm_pkg::CMD_READ_DATA: begin
              r_next.state    = qsm_pkg::ST_RDATA;
              r_next.tx       = p_reg.shadow[7:0];
              r_next.out_rise = p_reg.shadow[7:4];
              rd_start        = 1'b1;
            end
            default: begin
              r_next.state = qsm_pkg::ST_ABORT;
            end
          endcase
        end
        qsm_pkg::ST_ADDR: begin
          r_next.addr  = byte_in;
          r_next.state = qsm_pkg::ST_WDATA;
        end
        qsm_pkg::ST_WDATA: begin
          // A full buffer drops the byte and holds the address
          push = 1'b1;
          if (fifo_ready) begin
            r_next.addr = r_reg.addr + 8'h01;
          end
        end
        qsm_pkg::ST_WSTAT: begin
          st_we        = 1'b1;
          r_next.state = qsm_pkg::ST_ABORT;
        end
        qsm_pkg::ST_RSTAT, qsm_pkg::ST_RDATA: begin
          r_next.tx       = read_byte;
          r_next.out_rise = read_byte[7:4];
          rd_start        = r_reg.state == qsm_pkg::ST_RDATA;
        end
        default: begin
          r_next.state = r_reg.state;
        end
      endcase
    end
  end

  // Select high holds the frame cleared, so no partial instruction survives
  always_ff @(posedge die_two_serial_clock_i or posedge frame_clr) begin
    if (frame_clr) begin
      r_reg <= FRAME_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Falling-edge launch and capture
  always_comb begin
    f_next          = f_reg;
    tx_sel          = r_reg.tx << r_reg.cnt;
    f_next.out_fall = ddr_data ? r_reg.tx[3:0] : (quad ? tx_sel[7:4] : {3'b000, tx_sel[7]});
    f_next.fall_nib = data_line_i;
  end

  always_ff @(negedge die_two_serial_clock_i or posedge frame_clr) begin
    if (frame_clr) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // ==========================================================================
  // Persistent link-side state: status, error flag, read shadow
  always_comb begin
    p_next     = p_reg;
    p_next.tg1 = c_reg.tog;
    p_next.tg2 = p_reg.tg1;
    p_next.tg3 = p_reg.tg2;
    // Hold has been stable for two link edges once the toggle shows
    if (p_reg.tg2 != p_reg.tg3) begin
      p_next.shadow = c_reg.hold;
    end
    if (st_we) begin
      p_next.status = byte_in;
    end
    if (rd_start) begin
      p_next.irq_n = ~p_reg.shadow[8];
    end
  end

  always_ff @(posedge die_two_serial_clock_i or negedge die_two_reset_n_i) begin
    if (!die_two_reset_n_i) begin
      p_reg <= PERSIST_RESET;
    end else begin
      p_reg <= p_next;
    end
  end

  // ==========================================================================
  // System-clock side: reset pin sync and read word hand-off
  always_comb begin
    c_next        = c_reg;
    c_next.rst_s1 = die_two_reset_n_i;
    c_next.rst_s2 = c_reg.rst_s1;
    // Reloading faster than a few link edges can tear the shadow copy
    if (read_load_i) begin
      c_next.hold = {read_uncorrectable_i, read_word_i};
      c_next.tog  = ~c_reg.tog;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // ==========================================================================
  // Write data buffer towards the array
  qsm_fifo #(
    .WIDTH (qsm_pkg::ADDR_W + qsm_pkg::DATA_W),
    .DEPTH (qsm_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .wclk_i    (die_two_serial_clock_i),
    .wrst_n_i  (die_two_reset_n_i),
    .w_valid_i (push),
    .w_ready_o (fifo_ready),
    .w_data_i  ({r_reg.addr, byte_in}),
    .rclk_i    (clock_i),
    .rrst_i    (reset_i | ~c_reg.rst_s2),
    .r_valid_o (write_valid_o),
    .r_ready_i (write_ready_i),
    .r_data_o  (fifo_out)
  );

  assign write_addr_o = fifo_out[15:8];
  assign write_data_o = fifo_out[7:0];

  // ==========================================================================
  // Pins
  assign dout    = (ddr_data && die_two_serial_clock_i) ? r_reg.out_rise : f_reg.out_fall;
  assign oe_read = read_state & ~frame_clr;

  assign die_two_serial_out_o          = dout[0];
  assign die_two_serial_out_oe_o       = oe_read & ~quad;
  assign data_line_o                   = dout;
  assign data_line_oe_o                = {4{oe_read & quad}};
  assign die_two_uncorrectable_irq_n_o = p_reg.irq_n;
  assign die_active_o                  = c_reg.rst_s2;
  assign quad_mode_o                   = quad;
  assign double_rate_o                 = ddr_on;

endmodule : qsm_port

// [qsm_port_monitor.sv]
// Checker for the die-two port pins and core outputs
module qsm_port_monitor (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       die_two_select_n_i,
  input wire logic       die_two_reset_n_i,
  input wire logic       die_two_serial_out_oe_o,
  input wire logic [3:0] data_line_oe_o,
  input wire logic       die_two_uncorrectable_irq_n_o,
  input wire logic       write_valid_o,
  input wire logic       write_ready_i,
  input wire logic [7:0] write_addr_o,
  input wire logic [7:0] write_data_o,
  input wire logic       die_active_o,
  input wire logic       quad_mode_o,
  input wire logic       double_rate_o
);
  timeunit 1ns;
  timeprecision 10ps;
  // ========
  // Properties
  default clocking mon_cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_STANDBY_OE: assert property (die_two_select_n_i && $past(die_two_select_n_i)
    |-> !die_two_serial_out_oe_o && data_line_oe_o == 4'h0) else $error("Output driven in standby");
  AST_RESET_OE: assert property (!die_two_reset_n_i && !$past(die_two_reset_n_i)
    |-> !die_two_serial_out_oe_o && data_line_oe_o == 4'h0) else $error("Output driven in reset");
  AST_ONE_DRIVER: assert property (!(die_two_serial_out_oe_o && data_line_oe_o != 4'h0))
    else $error("Serial and quad outputs both driven");
  AST_QUAD_OE_ALL: assert property (data_line_oe_o == 4'h0 || data_line_oe_o == 4'hF)
    else $error("Quad lines enabled partly");
  AST_SERIAL_OE_SINGLE: assert property (die_two_serial_out_oe_o |-> !quad_mode_o)
    else $error("Serial out driven in quad mode");
  AST_DDR_QUAD: assert property (double_rate_o |-> quad_mode_o) else $error("Double rate outside quad");
  AST_FIFO_HOLD: assert property (write_valid_o && !write_ready_i && die_two_reset_n_i
    |=> write_valid_o && $stable(write_addr_o) && $stable(write_data_o)) else $error("Write word not held");
  AST_IRQ_RESET: assert property (!die_two_reset_n_i [*4] |-> die_two_uncorrectable_irq_n_o)
    else $error("Interrupt low in reset");
  AST_ACTIVE_LOW: assert property (!die_two_reset_n_i [*4] |-> !die_active_o)
    else $error("Active while reset pin low");
  AST_ACTIVE_HIGH: assert property (die_two_reset_n_i [*4] |-> die_active_o)
    else $error("Not active after reset pin high");
endmodule : qsm_port_monitor

bind qsm_port qsm_port_monitor i_mon (
  .clock_i(clock_i), .reset_i(reset_i), .die_two_select_n_i(die_two_select_n_i),
  .die_two_reset_n_i(die_two_reset_n_i), .die_two_serial_out_oe_o(die_two_serial_out_oe_o),
  .data_line_oe_o(data_line_oe_o), .die_two_uncorrectable_irq_n_o(die_two_uncorrectable_irq_n_o),
  .write_valid_o(write_valid_o), .write_ready_i(write_ready_i), .write_addr_o(write_addr_o),
  .write_data_o(write_data_o), .die_active_o(die_active_o), .quad_mode_o(quad_mode_o),
  .double_rate_o(double_rate_o));

// [qsm_sync.sv]
// Two-flop level synchroniser
module qsm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } qsm_sync_t;

  qsm_sync_t r_reg;
  qsm_sync_t r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;

endmodule : qsm_sync

// [test_quad_serial_memory_port_two.sv]
// Self-checking bench for the die-two serial memory port
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_quad_serial_memory_port_two;
  timeunit 1ns;
  timeprecision 10ps;
  // ========
  // Signals and instances
  logic       clock_i = 0;
  logic       reset_i, reset_n, guard_n, write_ready, read_load, read_bad;
  logic [7:0] read_word, wa, wd;
  logic       sel_n, sclk, si, hdq_oe, so, so_oe, irq_n, wv, active, quad, ddr;
  logic [3:0] hdq, dlo, dloe;
  wire  [3:0] dl = (dloe != 4'h0) ? dlo : (hdq_oe ? hdq : ~hdq);
  wire        so_seen = so_oe ? so : ~so;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  qsm_host_model i_host (.select_n_o(sel_n), .sclk_o(sclk), .si_o(si), .dq_o(hdq), .dq_oe_o(hdq_oe),
    .so_i(so_seen), .dq_i(dl));
  qsm_port i_dut (.clock_i(clock_i), .reset_i(reset_i), .die_two_select_n_i(sel_n),
    .die_two_serial_clock_i(sclk), .die_two_reset_n_i(reset_n), .die_two_serial_in_i(si),
    .die_two_serial_out_o(so), .die_two_serial_out_oe_o(so_oe), .die_two_status_guard_n_i(guard_n),
    .data_line_i(dl), .data_line_o(dlo), .data_line_oe_o(dloe), .die_two_uncorrectable_irq_n_o(irq_n),
    .write_valid_o(wv), .write_ready_i(write_ready), .write_addr_o(wa), .write_data_o(wd),
    .read_load_i(read_load), .read_word_i(read_word), .read_uncorrectable_i(read_bad),
    .die_active_o(active), .quad_mode_o(quad), .double_rate_o(ddr));
  always #5 clock_i = ~clock_i;
  // Whole run needs a few hundred cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ========
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  task automatic ws(input bit q, input bit m3, input logic [7:0] v);
    logic [7:0] r;
    i_host.start(m3);
    i_host.xb(q, qsm_pkg::CMD_WRITE_STATUS, 1, r);
    i_host.xb(q, v, 1, r);
    i_host.stop();
  endtask : ws
  task automatic rs(input bit q, input bit m3, output logic [7:0] v);
    i_host.start(m3);
    i_host.xb(q, qsm_pkg::CMD_READ_STATUS, 1, v);
    i_host.xb(q, 8'h00, 0, v);
    i_host.stop();
  endtask : rs
  task automatic dws(input logic [7:0] v);
    logic [7:0] r;
    i_host.start(0);
    i_host.xb(1, qsm_pkg::CMD_WRITE_STATUS, 1, r);
    i_host.ddr(v);
    i_host.pulse();
    i_host.stop();
  endtask : dws
  task automatic wait_active();
    for (int i = 0; i < 20 && active !== 1'b1; i++) tick(1);
    tick(3);
    `CHK("die_active", 1'b1, active);
  endtask : wait_active
  // ========
  // Scenarios
  task automatic t_standby();
    i_host.noise();
    tick(4);
    `CHK("quad_mode", 1'b0, quad);
  endtask : t_standby
  task automatic t_guard();
    logic [7:0] v;
    ws(0, 0, 8'h80);
    rs(0, 0, v);
    `CHK("status", 8'h80, v);
    @(posedge clock_i) guard_n <= 0;
    ws(0, 1, 8'h00);
    rs(0, 1, v);
    `CHK("guarded status", 8'h80, v);
    @(posedge clock_i) guard_n <= 1;
    ws(0, 0, 8'hC0);
    `CHK("quad_mode", 1'b1, quad);
    @(posedge clock_i) guard_n <= 0;
    ws(1, 0, 8'h40);
    rs(1, 0, v);
    `CHK("quad status", 8'h40, v);
  endtask : t_guard
  task automatic t_reset_pin();
    logic [7:0] v;
    i_host.start(0);
    i_host.xb(1, qsm_pkg::CMD_READ_STATUS, 1, v);
    i_host.xb(1, 8'h00, 0, v);
    `CHK("read oe", 5'h0F, {so_oe, dloe});
    @(posedge clock_i) reset_n <= 0;
    tick(4);
    `CHK("reset oe", 5'h00, {so_oe, dloe});
    `CHK("reset status", 1'b0, quad);
    i_host.stop();
    @(posedge clock_i) reset_n <= 1;
    wait_active();
    @(posedge clock_i) reset_i <= 1;
    tick(2);
    `CHK("active in core reset", 1'b0, active);
    @(posedge clock_i) reset_i <= 0;
    wait_active();
  endtask : t_reset_pin
  // Eight slots plus the output register take nine bytes; the tenth is dropped
  // First byte after a pause still meets the stale read pointer and is dropped
  task automatic t_fifo();
    logic [7:0] r;
    int         k;
    ws(0, 0, 8'h40);
    @(posedge clock_i) write_ready <= 0;
    i_host.start(0);
    i_host.xb(1, qsm_pkg::CMD_WRITE_DATA, 1, r);
    i_host.xb(1, 8'h10, 1, r);
    for (int i = 0; i < 10; i++) i_host.xb(1, 8'(8'hA0 + i), 1, r);
    k = 0;
    @(posedge clock_i) write_ready <= 1;
    fork
      begin
        #400;
        i_host.xb(1, 8'h55, 1, r);
        i_host.xb(1, 8'hEE, 1, r);
        i_host.stop();
      end
      repeat (150) begin
        @(negedge clock_i);
        if (wv === 1'b1) begin
          `CHK("write addr", 8'(8'h10 + k), wa);
          `CHK("write data", (k < 9) ? 8'(8'hA0 + k) : 8'hEE, wd);
          k++;
        end
      end
    join
    `CHK("word count", 10, k);
  endtask : t_fifo
  task automatic t_read(input logic [7:0] w, input logic bad);
    logic [7:0] v;
    @(posedge clock_i) begin
      read_word <= w;
      read_bad <= bad;
      read_load <= 1;
    end
    @(posedge clock_i) read_load <= 0;
    i_host.start(0);
    i_host.xb(1, qsm_pkg::CMD_READ_DATA, 1, v);
    repeat (3) i_host.xb(1, 8'h00, 0, v);
    i_host.stop();
    tick(4);
    `CHK("read data", w, v);
    `CHK("irq_n", ~bad, irq_n);
  endtask : t_read
  task automatic t_modes();
    logic [7:0] v;
    ws(1, 0, 8'h60);
    i_host.start(1);
    tick(4);
    `CHK("double_rate mode3", 1'b0, ddr);
    i_host.xb(1, qsm_pkg::CMD_READ_STATUS, 1, v);
    i_host.xb(1, 8'h00, 0, v);
    i_host.stop();
    `CHK("status mode3", 8'h60, v);
    i_host.start(0);
    tick(4);
    `CHK("double_rate mode0", 1'b1, ddr);
    i_host.stop();
    dws(8'h63);
    i_host.start(0);
    i_host.xb(1, qsm_pkg::CMD_READ_STATUS, 1, v);
    i_host.ddr_rd(v);
    i_host.stop();
    `CHK("status ddr read", 8'h63, v);
    dws(8'h40);
    rs(1, 0, v);
    `CHK("status ddr write", 8'h40, v);
  endtask : t_modes
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    reset_i = 1;
    reset_n = 0;
    guard_n = 1;
    write_ready = 1;
    read_load = 0;
    read_word = 8'h00;
    read_bad = 0;
    tick(3);
    reset_i <= 0;
    reset_n <= 1;
    wait_active();
    t_standby();
    t_guard();
    t_reset_pin();
    t_fifo();
    t_read(8'h3C, 1'b1);
    t_read(8'h99, 1'b0);
    t_modes();
    finish_test();
  end
endmodule : test_quad_serial_memory_port_two
